// *** ecp_port_register_decode.sv ***
// parallel port register decode with mode-dependent map and forward fifo
// Operation
// RL1: decode three-bit mode: standard, bidir, fifo, extended, enhanced, reserved, test, config.
// RL2: enhanced mode only when enabled by chip configuration, else not available.
// RL3: software never programs reserved or undefined mode codes.
// RL4: mode 111 gives config A at 0x400, config B at 0x401; else fifos.
// RL5: status, control and extended control reachable in every mode.
// RL6: every offset is added to the port base address before compare.
// RL7: every address match is qualified by the address enable signal.
// RL8: data register clears to zero on system reset.
// RL9: data register captures bus data on rising edge of write strobe.
// RL10: stored data driven uninverted onto the eight parallel data lines.
// RL11: data register read returns sampled parallel data lines.
// RL12: mode 011 write at 0x000 enters fifo tagged as address/RLE.
// RL13: address fifo entry only used while direction is forward; the code pushes and sends it whatever the direction bit.
// RL14: status bits 0 to 2 always read zero.
// RL15: status bit 3 reads the fault input level.
// RL16: status bit 4 reads the select input level.
// RL17: status bit 5 reads the paper error input level.
// RL18: status bit 6 reads the acknowledge input level.
// RL19: status bit 7 reads the complement of the busy input.
// RL20: writes to the status port are ignored.
`include "ecp_port_params.svh"

module ecp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic flush,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [CW-1:0] count_q, count_d;
	logic push, pop;

	assign inReady = (count_q != CW'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData = mem[rdPtr_q];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb
	begin
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		count_d = count_q;
		if (flush)
		begin
			wrPtr_d = '0;
			rdPtr_d = '0;
			count_d = '0;
		end
		else
		begin
			if (push)
				wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			if (pop)
				rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			count_d = count_q + CW'(push) - CW'(pop);
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
		end
	end

	// storage has no reset, only the pointers and the count do
	always_ff @(posedge clk_sys)
	begin
		if (push && !flush)
			mem[wrPtr_q] <= inData;
	end
endmodule : ecp_fifo

module ecp_port_register_decode #(
	parameter int FIFO_DEPTH = 32
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// host bus pins
	input wire ecp_port_pkg::ioaddr_t hostAddr,
	input wire ecp_port_pkg::byte_t hostDataIn,
	output ecp_port_pkg::byte_t hostDataOut,
	output logic hostDataOe,
	input wire logic ioReadN,
	input wire logic ioWriteN,
	input wire logic addrEnable,
	output logic hostFifoReady,
	// chip configuration
	input wire ecp_port_pkg::ioaddr_t portBase,
	input wire logic enhancedEnable,
	input wire logic [2:0] irqSelect,
	input wire logic [2:0] dmaSelect,
	input wire logic irqLineLevel,
	output logic enhancedActive,
	// parallel cable
	input wire ecp_port_pkg::byte_t parallelDataIn,
	output ecp_port_pkg::byte_t parallelDataOut,
	output logic parallelDataOe,
	input wire logic peripheralFaultIn,
	input wire logic selectIn,
	input wire logic paperErrorIn,
	input wire logic peripheralAckIn,
	input wire logic busyIn,
	output logic strobeN,
	output logic autoFeedN,
	output logic initN,
	output logic selectOutN,
	// forward stream to the link handshake
	output logic xmitValid,
	input wire logic xmitReady,
	output ecp_port_pkg::byte_t xmitData,
	output logic xmitAddrTag
);
	import ecp_port_pkg::*;
	localparam int SW = 16 + 8 + 8 + 8;

	logic [SW-1:0] pinS1_q, pinS2_q;
	logic [2:0] strbS1_q, strbS2_q, strbS3_q;
	ioaddr_t addrS;
	byte_t busS, pdS;
	logic [4:0] statS;
	logic rdLow, wrRise, rdRise;
	byte_t data_q, data_d, hostOut_q, hostOut_d, lastTest_q, lastTest_d;
	logic [5:0] ctrl_q, ctrl_d;
	logic [4:0] ecr_q, ecr_d;
	logic hostOe_q, hostOe_d, enh_q, enh_d;
	byte_t pdOut_q, pdOut_d;
	logic pdOe_q, pdOe_d, fifoRdy_q, fifoRdy_d;
	logic [3:0] pinCtl_q, pinCtl_d;
	logic xv_q, xv_d, xt_q, xt_d;
	byte_t xd_q, xd_d;
	mode_t mode;
	logic hitData, hitStat, hitCtrl, hitFifo, hitCfgB, hitEcr;
	logic pushValid, pushTag, inReady, outValid, outReady, popTest, flush;
	byte_t pushData;
	logic [8:0] outData;

	// pins and strobes from outside pass two flops before use
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			pinS1_q <= '0;
			pinS2_q <= '0;
			strbS1_q <= 3'h7;
			strbS2_q <= 3'h7;
			strbS3_q <= 3'h7;
		end
		else
		begin
			pinS1_q <= {hostAddr, hostDataIn, parallelDataIn, peripheralFaultIn, selectIn,
				paperErrorIn, peripheralAckIn, busyIn, 3'h0};
			pinS2_q <= pinS1_q;
			strbS1_q <= {ioReadN, ioWriteN, addrEnable};
			strbS2_q <= strbS1_q;
			strbS3_q <= strbS2_q;
		end
	end

	assign addrS = pinS2_q[39:24];
	assign busS = pinS2_q[23:16];
	assign pdS = pinS2_q[15:8];
	assign statS = pinS2_q[7:3];
	assign rdLow = !strbS2_q[2];
	assign rdRise = strbS2_q[2] && !strbS3_q[2];
	assign wrRise = strbS2_q[1] && !strbS3_q[1]; // [RL9]

	// unavailable enhanced code falls back to standard decode; the reserved code passes through unchanged
	assign mode = (ecr_q[4:2] == `MODE_ENHANCED && !enhancedEnable) ? `MODE_STANDARD
		: ecr_q[4:2]; // [RL1] [RL2] [RL3]

	function automatic logic hit(input ioaddr_t a, input ioaddr_t base, input ioaddr_t ofs,
		input logic aen);
		hit = !aen && (a == ioaddr_t'(base + ofs)); // [RL6] [RL7]
	endfunction : hit

	always_comb
	begin
		hitData = hit(addrS, portBase, `OFS_DATA, strbS2_q[0]);
		hitStat = hit(addrS, portBase, `OFS_STATUS, strbS2_q[0]); // [RL5]
		hitCtrl = hit(addrS, portBase, `OFS_CONTROL, strbS2_q[0]);
		hitFifo = hit(addrS, portBase, `OFS_FIFO_CFGA, strbS2_q[0]);
		hitCfgB = hit(addrS, portBase, `OFS_CFGB, strbS2_q[0]);
		hitEcr = hit(addrS, portBase, `OFS_ECR, strbS2_q[0]);
	end

	// fill side: address byte at 0x000 in mode 011, data bytes at 0x400
	always_comb
	begin
		pushValid = 1'b0;
		pushTag = 1'b0;
		pushData = busS;
		if (wrRise && hitData && mode == `MODE_EXTENDED)
		begin
			pushValid = 1'b1;
			pushTag = 1'b1; // [RL12]
		end
		else if (wrRise && hitFifo && (mode == `MODE_COMPAT_FIFO
			|| mode == `MODE_EXTENDED || mode == `MODE_TEST))
			pushValid = 1'b1; // [RL4]
	end

	assign flush = (mode == `MODE_STANDARD);
	assign popTest = rdRise && hitFifo && mode == `MODE_TEST;
	// one byte waits in the send register, so the stream holds depth plus one
	assign outReady = (mode == `MODE_TEST) ? popTest
		: ((mode == `MODE_COMPAT_FIFO || mode == `MODE_EXTENDED) && (!xv_q || xmitReady));

	ecp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.reset(reset),
		.flush(flush),
		.inValid(pushValid),
		.inReady(inReady),
		.inData({pushTag, pushData}),
		.outValid(outValid),
		.outReady(outReady),
		.outData(outData)
	);

	always_comb
	begin
		data_d = data_q;
		ctrl_d = ctrl_q;
		ecr_d = ecr_q;
		lastTest_d = lastTest_q;
		if (wrRise && hitData && (mode == `MODE_STANDARD || mode == `MODE_BIDIR))
			data_d = busS; // [RL9]
		if (wrRise && hitCtrl)
			ctrl_d = busS[5:0];
		if (wrRise && hitEcr)
			ecr_d = busS[7:3];
		// a write to the status offset matches no branch and is dropped [RL20]
		if (popTest && outValid)
			lastTest_d = outData[7:0];
		hostOe_d = rdLow && (hitData || hitStat || hitCtrl || hitFifo || hitCfgB || hitEcr);
		hostOut_d = 8'h00;
		if (hitStat) // [RL15] [RL16] [RL17] [RL18] [RL19]
			hostOut_d = {!statS[0], statS[1], statS[2], statS[3], statS[4], 3'h0}; // [RL14]
		else if (hitCtrl)
			hostOut_d = {2'h0, ctrl_q};
		else if (hitEcr)
			hostOut_d = {ecr_q, 1'b0, !inReady, !outValid};
		else if (hitData && (mode == `MODE_STANDARD || mode == `MODE_BIDIR))
			hostOut_d = pdS; // [RL11]
		else if (hitFifo && mode == `MODE_CONFIG)
			hostOut_d = `CONFIG_A_VALUE; // [RL4]
		else if (hitFifo && mode == `MODE_TEST)
			hostOut_d = outValid ? outData[7:0] : lastTest_q;
		else if (hitCfgB && mode == `MODE_CONFIG)
			hostOut_d = {1'b0, irqLineLevel, irqSelect, dmaSelect};
		// standard and fifo mode 010 always drive forward; all other modes obey the direction bit
		pdOut_d = data_d; // [RL10]
		pdOe_d = (mode == `MODE_STANDARD || mode == `MODE_COMPAT_FIFO)
			|| !ctrl_d[`CTRL_DIR_BIT];
		pinCtl_d = {!ctrl_d[3], ctrl_d[2], !ctrl_d[1], !ctrl_d[0]};
		enh_d = (ecr_q[4:2] == `MODE_ENHANCED) && enhancedEnable; // [RL2]
		fifoRdy_d = inReady;
		xv_d = xv_q;
		xd_d = xd_q;
		xt_d = xt_q;
		if (xv_q && xmitReady)
			xv_d = 1'b0;
		if (outValid && outReady && mode != `MODE_TEST)
		begin
			xv_d = 1'b1;
			xd_d = outData[7:0];
			xt_d = outData[8]; // [RL12]
		end
		if (flush)
			xv_d = 1'b0;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			data_q <= `DATA_RESET; // [RL8]
			ctrl_q <= `CONTROL_RESET;
			ecr_q <= `ECR_RESET;
			lastTest_q <= 8'h00;
			hostOut_q <= 8'h00;
			hostOe_q <= 1'b0;
			pdOut_q <= `DATA_RESET;
			pdOe_q <= 1'b1;
			pinCtl_q <= 4'hB;
			enh_q <= 1'b0;
			fifoRdy_q <= 1'b1;
			xv_q <= 1'b0;
			xd_q <= 8'h00;
			xt_q <= 1'b0;
		end
		else
		begin
			data_q <= data_d;
			ctrl_q <= ctrl_d;
			ecr_q <= ecr_d;
			lastTest_q <= lastTest_d;
			hostOut_q <= hostOut_d;
			hostOe_q <= hostOe_d;
			pdOut_q <= pdOut_d;
			pdOe_q <= pdOe_d;
			pinCtl_q <= pinCtl_d;
			enh_q <= enh_d;
			fifoRdy_q <= fifoRdy_d;
			xv_q <= xv_d;
			xd_q <= xd_d;
			xt_q <= xt_d;
		end
	end

	assign hostDataOut = hostOut_q;
	assign hostDataOe = hostOe_q;
	assign hostFifoReady = fifoRdy_q;
	assign enhancedActive = enh_q;
	assign parallelDataOut = pdOut_q;
	assign parallelDataOe = pdOe_q;
	assign {selectOutN, initN, autoFeedN, strobeN} = pinCtl_q;
	assign xmitValid = xv_q;
	assign xmitData = xd_q;
	assign xmitAddrTag = xt_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence sDataWrite;
		wrRise && hitData && (mode == `MODE_STANDARD || mode == `MODE_BIDIR);
	endsequence
	sequence sAddrWrite;
		wrRise && hitData && mode == `MODE_EXTENDED && inReady;
	endsequence

	a_data_write_drive: assert property (sDataWrite |=> ##1 parallelDataOut == $past(busS, 2)) // [RL9] [RL10]
		else $error("data write not driven onto parallel lines");
	a_data_read_lines: assert property (rdLow && hitData && mode == `MODE_STANDARD
		|=> hostDataOut == $past(pdS) && hostDataOe) // [RL11]
		else $error("data read did not return line levels");
	a_status_low_bits: assert property (rdLow && hitStat |=> hostDataOut[2:0] == 3'h0) // [RL14]
		else $error("status low bits not zero");
	a_status_input_levels: assert property (rdLow && hitStat
		|=> hostDataOut[6:3] == {$past(statS[1]), $past(statS[2]), $past(statS[3]),
		$past(statS[4])}) // [RL15] [RL16] [RL17] [RL18]
		else $error("status bits do not follow inputs");
	a_status_busy_inv: assert property (rdLow && hitStat |=> hostDataOut[7] != $past(statS[0])) // [RL19]
		else $error("status busy bit not inverted");
	a_aen_blocks_read: assert property (strbS2_q[0] |=> !hostDataOe) // [RL7]
		else $error("read answered while address enable high");
	a_config_a_read: assert property (rdLow && hitFifo && mode == `MODE_CONFIG
		|=> hostDataOut == `CONFIG_A_VALUE) // [RL4]
		else $error("config A value wrong");
	a_ecr_any_mode: assert property (rdLow && hitEcr |=> hostDataOut[7:5] == $past(ecr_q[4:2])) // [RL5]
		else $error("extended control unreadable");
	a_addr_tag_push: assert property (sAddrWrite |-> pushValid && pushTag) // [RL12]
		else $error("address byte not pushed tagged");
	a_reset_data_zero: assert property ($fell(reset) |-> data_q == `DATA_RESET) // [RL8]
		else $error("data register not cleared by reset");
	a_enhanced_gate: assert property (!enhancedEnable |=> !enhancedActive) // [RL2]
		else $error("enhanced mode active without enable");
	a_status_write_ignored: assert property (wrRise && hitStat |=> $stable(ctrl_q)
		&& $stable(data_q) && $stable(ecr_q)) // [RL20]
		else $error("status write changed state");
endmodule : ecp_port_register_decode

// *** ecp_port_params.svh ***
// offsets, field positions, mode codes and reset values of the parallel port register decode
`ifndef ECP_PORT_PARAMS_SVH
`define ECP_PORT_PARAMS_SVH

`define OFS_DATA 16'h0000
`define OFS_STATUS 16'h0001
`define OFS_CONTROL 16'h0002
`define OFS_FIFO_CFGA 16'h0400
`define OFS_CFGB 16'h0401
`define OFS_ECR 16'h0402

`define MODE_STANDARD 3'h0
`define MODE_BIDIR 3'h1
`define MODE_COMPAT_FIFO 3'h2
`define MODE_EXTENDED 3'h3
`define MODE_ENHANCED 3'h4
`define MODE_RESERVED 3'h5
`define MODE_TEST 3'h6
`define MODE_CONFIG 3'h7

`define ECR_MODE_HI 7
`define ECR_MODE_LO 5
`define ECR_FULL_BIT 1
`define ECR_EMPTY_BIT 0
`define CTRL_DIR_BIT 5

`define DATA_RESET 8'h00
`define CONTROL_RESET 6'h00
`define ECR_RESET 5'h02
`define CONFIG_A_VALUE 8'h10

`endif

// *** ecp_port_pkg.sv ***
// shared types of the parallel port register decode
package ecp_port_pkg;
	typedef logic [2:0] mode_t;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] ioaddr_t;
endpackage : ecp_port_pkg

// *** peripheral_model.sv ***
// far-side peripheral: status levels, reverse data and stream sink
module peripheral_model
	import ecp_port_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// cable data
	input wire ecp_port_pkg::byte_t parallelDataOut,
	input wire logic parallelDataOe,
	output ecp_port_pkg::byte_t parallelDataIn,
	// status lines
	output logic peripheralFaultIn,
	output logic selectIn,
	output logic paperErrorIn,
	output logic peripheralAckIn,
	output logic busyIn,
	// forward stream sink
	input wire logic xmitValid,
	output logic xmitReady,
	input wire ecp_port_pkg::byte_t xmitData,
	input wire logic xmitAddrTag
);
	timeunit 1ns;
	timeprecision 100ps;
	byte_t driveData = 8'h3C;
	logic [4:0] lines = 5'h00;
	logic stall = 1'b0;
	logic [8:0] got[$];
	// host released the lines: our own byte shows, never a stale one
	assign parallelDataIn = parallelDataOe ? parallelDataOut : driveData;
	assign {busyIn, peripheralAckIn, paperErrorIn, selectIn, peripheralFaultIn} = lines;
	assign xmitReady = !stall;
	always @(posedge clk_sys)
	begin
		if (!reset && xmitValid && xmitReady)
			got.push_back({xmitAddrTag, xmitData});
	end
endmodule : peripheral_model

// *** tb_top.sv ***
// self-checking testbench of the parallel port register decode
`include "ecp_port_params.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import ecp_port_pkg::*;
	localparam ioaddr_t BASE = 16'h0378;
	localparam logic [2:0] IRQSEL = 3'h5;
	localparam logic [2:0] DMASEL = 3'h3;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic ioReadN = 1'b1;
	logic ioWriteN = 1'b1;
	logic addrEnable = 1'b0;
	logic enhancedEnable = 1'b0;
	ioaddr_t hostAddr = 16'h0000;
	byte_t hostDataIn = 8'h00;
	byte_t hostDataOut, parallelDataIn, parallelDataOut, xmitData;
	logic hostDataOe, hostFifoReady, enhancedActive, parallelDataOe;
	logic strobeN, autoFeedN, initN, selectOutN, xmitValid, xmitReady, xmitAddrTag;
	logic peripheralFaultIn, selectIn, paperErrorIn, peripheralAckIn, busyIn;
	int err_count = 0;
	int compares = 0;

	ecp_port_register_decode #(.FIFO_DEPTH(4)) uut (.clk_sys(clk_sys), .reset(reset),
		.hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
		.hostDataOe(hostDataOe), .ioReadN(ioReadN), .ioWriteN(ioWriteN),
		.addrEnable(addrEnable), .hostFifoReady(hostFifoReady), .portBase(BASE),
		.enhancedEnable(enhancedEnable), .irqSelect(IRQSEL), .dmaSelect(DMASEL),
		.irqLineLevel(1'b1), .enhancedActive(enhancedActive),
		.parallelDataIn(parallelDataIn), .parallelDataOut(parallelDataOut),
		.parallelDataOe(parallelDataOe), .peripheralFaultIn(peripheralFaultIn),
		.selectIn(selectIn), .paperErrorIn(paperErrorIn), .peripheralAckIn(peripheralAckIn),
		.busyIn(busyIn), .strobeN(strobeN), .autoFeedN(autoFeedN), .initN(initN),
		.selectOutN(selectOutN), .xmitValid(xmitValid), .xmitReady(xmitReady),
		.xmitData(xmitData), .xmitAddrTag(xmitAddrTag));

	peripheral_model peer (.clk_sys(clk_sys), .reset(reset),
		.parallelDataOut(parallelDataOut), .parallelDataOe(parallelDataOe),
		.parallelDataIn(parallelDataIn), .peripheralFaultIn(peripheralFaultIn),
		.selectIn(selectIn), .paperErrorIn(paperErrorIn), .peripheralAckIn(peripheralAckIn),
		.busyIn(busyIn), .xmitValid(xmitValid), .xmitReady(xmitReady),
		.xmitData(xmitData), .xmitAddrTag(xmitAddrTag));

	initial
	begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic test_done;
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	task automatic check(string what, logic [8:0] exp, logic [8:0] got);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check

	// address and data settle three cycles before the strobe, as the pins are synchronised
	task automatic bus_write(ioaddr_t ofs, byte_t d, logic aen = 1'b0, ioaddr_t base = BASE);
		@(posedge clk_sys) #1;
		hostAddr = base + ofs;
		hostDataIn = d;
		addrEnable = aen;
		repeat (3) @(posedge clk_sys) #1;
		ioWriteN = 1'b0;
		repeat (4) @(posedge clk_sys) #1;
		ioWriteN = 1'b1;
		repeat (6) @(posedge clk_sys) #1;
		addrEnable = 1'b0;
	endtask : bus_write

	task automatic bus_read(ioaddr_t ofs, output byte_t d, output logic oe,
		input ioaddr_t base = BASE);
		@(posedge clk_sys) #1;
		hostAddr = base + ofs;
		ioReadN = 1'b0;
		repeat (6) @(posedge clk_sys) #1;
		d = hostDataOut;
		oe = hostDataOe;
		ioReadN = 1'b1;
		repeat (4) @(posedge clk_sys) #1;
	endtask : bus_read

	task automatic rdchk(string what, ioaddr_t ofs, byte_t exp);
		byte_t d;
		logic oe;
		bus_read(ofs, d, oe);
		check({what, " enable"}, 9'h001, {8'h00, oe});
		check(what, {1'b0, exp}, {1'b0, d});
	endtask : rdchk

	// only defined codes are ever programmed
	task automatic set_mode(mode_t m);
		bus_write(`OFS_ECR, {m, 5'h14});
	endtask : set_mode

	task automatic t_data;
		check("data after reset", 9'h000, {1'b0, parallelDataOut});
		check("control pins reset", 9'h00B, {5'h00, selectOutN, initN, autoFeedN, strobeN});
		rdchk("data read reset", `OFS_DATA, 8'h00);
		bus_write(`OFS_DATA, 8'hA5);
		check("data lines", 9'h0A5, {1'b0, parallelDataOut});
		rdchk("data read out", `OFS_DATA, 8'hA5);
		set_mode(`MODE_BIDIR);
		bus_write(`OFS_CONTROL, 8'h2F);
		check("control pins", 9'h004, {5'h00, selectOutN, initN, autoFeedN, strobeN});
		check("line enable", 9'h000, {8'h00, parallelDataOe});
		rdchk("data read lines", `OFS_DATA, 8'h3C);
		bus_write(`OFS_CONTROL, 8'h00);
		set_mode(`MODE_STANDARD);
		bus_write(`OFS_DATA, 8'h11, 1'b1);
		check("data dma cycle", 9'h0A5, {1'b0, parallelDataOut});
		bus_write(`OFS_DATA, 8'h22, 1'b0, 16'h0278);
		check("data other base", 9'h0A5, {1'b0, parallelDataOut});
		reset = 1'b1;
		repeat (2) @(posedge clk_sys) #1;
		reset = 1'b0;
		repeat (4) @(posedge clk_sys) #1;
		check("data after mid reset", 9'h000, {1'b0, parallelDataOut});
		rdchk("ext control reset", `OFS_ECR, 8'h11);
	endtask : t_data

	task automatic t_modes;
		mode_t ml[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
		logic [4:0] l;
		byte_t st;
		foreach (ml[i])
		begin
			l = 5'(i * 7 + 3);
			peer.lines = l;
			st = {~l[4], l[3:0], 3'h0};
			set_mode(ml[i]);
			bus_write(`OFS_STATUS, 8'hFF);
			rdchk("status", `OFS_STATUS, st);
			rdchk("control", `OFS_CONTROL, 8'h00);
			rdchk("ext control", `OFS_ECR, {ml[i], 5'h11});
		end
		rdchk("config a", `OFS_FIFO_CFGA, `CONFIG_A_VALUE);
		rdchk("config b", `OFS_CFGB, {2'b01, IRQSEL, DMASEL});
		set_mode(`MODE_ENHANCED);
		check("enhanced off", 9'h000, {8'h00, enhancedActive});
		enhancedEnable = 1'b1;
		repeat (3) @(posedge clk_sys) #1;
		check("enhanced on", 9'h001, {8'h00, enhancedActive});
		set_mode(`MODE_STANDARD);
	endtask : t_modes

	task automatic t_stream;
		logic [8:0] exp[6];
		byte_t d;
		logic oe;
		exp[0] = 9'h15A;
		set_mode(`MODE_EXTENDED);
		bus_write(`OFS_CONTROL, 8'h00);
		peer.stall = 1'b1;
		bus_write(`OFS_DATA, 8'h5A);
		for (int i = 1; i < 6; i++)
		begin
			exp[i] = {1'b0, 8'(8'h80 + i)};
			bus_write(`OFS_FIFO_CFGA, exp[i][7:0]);
		end
		check("fifo ready", 9'h000, {8'h00, hostFifoReady});
		bus_read(`OFS_ECR, d, oe);
		check("full flag", 9'h001, {8'h00, d[`ECR_FULL_BIT]});
		peer.stall = 1'b0;
		repeat (30) @(posedge clk_sys) #1;
		// four in the fifo plus one held in the send register; the sixth is lost
		check("sent count", 9'h005, 9'(peer.got.size()));
		foreach (peer.got[i])
			check("sent byte", exp[i], peer.got[i]);
		bus_read(`OFS_ECR, d, oe);
		check("empty flag", 9'h001, {8'h00, d[`ECR_EMPTY_BIT]});
	endtask : t_stream

	task automatic t_test;
		set_mode(`MODE_TEST);
		bus_write(`OFS_FIFO_CFGA, 8'h44);
		bus_write(`OFS_FIFO_CFGA, 8'h33);
		rdchk("test fifo first", `OFS_FIFO_CFGA, 8'h44);
		rdchk("test fifo second", `OFS_FIFO_CFGA, 8'h33);
		rdchk("test fifo reread", `OFS_FIFO_CFGA, 8'h33);
		set_mode(`MODE_STANDARD);
	endtask : t_test

	initial
	begin
		#100us;
		err_count++;
		test_done();
	end

	initial
	begin
		repeat (10) @(posedge clk_sys);
		#1 reset = 1'b0;
		repeat (4) @(posedge clk_sys);
		t_data();
		t_modes();
		t_stream();
		t_test();
		test_done();
	end
endmodule : tb_top
